/* File: logic/flash_host_map.svh */
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

// Clock period of mclk in ns
`define CLK_NS 10

// Command bytes placed on the data bus
`define CMD_CFG 8'hb8
`define CMD_RDSTAT 8'h70

// Configuration byte layout: code in the two low bits, upper six reserved and zero
`define CFG_RSVD_W 6
`define CFG_RSVD_VAL 6'h00

// Status byte field positions
`define ST_READY 7
`define ST_SUSP 6
`define ST_ERASE_ERR 5
`define ST_PROG_ERR 4
`define ST_VOLT 3
`define ST_RSVD_HI 2
`define ST_PROT 1
`define ST_RSVD_LO 0
// Reserved status bits 2 and 0 are dropped by this mask
`define ST_MASK 8'hfa

// Bus timing in ns and the derived cycle counts (least times round up)
`define T_WE_NS 70
`define T_REC_NS 30
`define T_RD_NS 150
`define T_PULSE_NS 250
`define WE_CYC ((`T_WE_NS + `CLK_NS - 1) / `CLK_NS)
`define REC_CYC ((`T_REC_NS + `CLK_NS - 1) / `CLK_NS)
`define RD_CYC ((`T_RD_NS + `CLK_NS - 1) / `CLK_NS)
`define PULSE_CYC ((`T_PULSE_NS + `CLK_NS - 1) / `CLK_NS)
// Data bus passes two sync stages before capture
`define SYNC_LAG 2
// A low on the ready pin longer than this many pulses counts as stuck in pulse mode
`define STUCK_MULT 4

`endif

/* File: logic/flash_host_pkg.sv */
`default_nettype none
package flash_host_pkg;
  // Bus sequencer states, Gray steps along idle, write low, write high, read
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WR_LO = 3'b001,
    ST_WR_HI = 3'b011,
    ST_RD = 3'b010,
    ST_FIN = 3'b110
  } bus_state_t;

  // Ready pin configuration codes
  typedef enum logic [1:0] {
    MODE_LEVEL = 2'b00,
    MODE_ERASE_PULSE = 2'b01,
    MODE_PROG_PULSE = 2'b10,
    MODE_ANY_PULSE = 2'b11
  } pin_mode_t;
endpackage : flash_host_pkg
`default_nettype wire

/* File: logic/pin_watch.sv */
`include "flash_host_map.svh"
`default_nettype none
module pin_watch
  import flash_host_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic ready_indicator_pin,
  input wire pin_mode_t mode,
  output logic ready_busy_level,
  output logic done_evt,
  output logic pin_stuck
);
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic done_q;
  logic stuck_q;
  logic [7:0] low_cnt_q;
  logic [7:0] low_cnt_d;
  logic is_level;
  logic rise;

  // Two stages first: the pin is open drain and arrives from outside mclk
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      sync1_q <= ready_indicator_pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Completion is the release edge in every mode: busy ends or a pulse ends
  assign is_level = (mode == MODE_LEVEL);
  assign rise = sync2_q && !prev_q;
  assign ready_busy_level = is_level ? sync2_q : 1'b1;
  assign low_cnt_d = sync2_q ? 8'h00 : (low_cnt_q == 8'hff ? low_cnt_q : low_cnt_q + 8'h01);

  // Low-width counter; in level mode a long low is just a long operation
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_q <= 8'h00;
      done_q <= 1'b0;
      stuck_q <= 1'b0;
    end else begin
      low_cnt_q <= low_cnt_d;
      done_q <= rise;
      stuck_q <= !is_level && (low_cnt_q > 8'(`STUCK_MULT * `PULSE_CYC));
    end
  end

  assign done_evt = done_q;
  assign pin_stuck = stuck_q;

  done_edge_a: assert property (@(posedge mclk) disable iff (!arst_n)
    done_evt |-> $past(sync2_q, 1) && !$past(sync2_q, 2))
    else $error("done event without a release edge on the ready pin");
  stuck_mode_a: assert property (@(posedge mclk) disable iff (!arst_n)
    pin_stuck |-> $past(mode) != MODE_LEVEL)
    else $error("stuck flag raised in level mode");
  cov_done: cover property (@(posedge mclk) disable iff (!arst_n) done_evt && !is_level);
endmodule : pin_watch
`default_nettype wire

/* File: logic/flash_status_host.sv */
// Notes on behaviour
// - Host restores level mode by writing B8h then 00h.
// - Host picks pulse mode with B8h then 01h, 02h or 03h.
// - Host writes the six reserved configuration bits as zero.
// - Host masks reserved status bits 2 and 0 when polling.
// - Host sees completion from the ready pin or status bit seven.
`include "flash_host_map.svh"
`default_nettype none
module flash_status_host
  import flash_host_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  // User side
  input wire logic cfg_req,
  input wire logic [1:0] cfg_code,
  input wire logic stat_req,
  output logic busy,
  output logic cfg_done,
  output logic stat_valid,
  output logic [7:0] stat_data,
  output logic engine_ready_flag,
  output logic program_voltage_fault_flag,
  output logic lock_cmd_error,
  output logic program_lock_error_flag,
  output logic erase_unlock_error_flag,
  output logic ready_busy_level,
  output logic done_evt,
  output logic pin_stuck,
  output logic [1:0] pin_mode,
  // Flash side
  output logic reset_powerdown_input_n,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic [7:0] dq_in,
  input wire logic ready_indicator_pin
);
  bus_state_t state_q;
  bus_state_t state_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [7:0] byte_q;
  logic [7:0] byte2_q;
  logic two_q;
  logic rd_q;
  logic cfg_q;
  pin_mode_t mode_q;
  pin_mode_t mode_pend_q;
  logic [7:0] dq_s1_q;
  logic [7:0] dq_s2_q;
  logic [7:0] stat_q;
  logic stat_valid_q;
  logic cfg_done_q;
  logic pwr_on_q;
  logic start_cfg;
  logic start_rd;
  logic lo_end;
  logic hi_end;
  logic rd_end;

  // Timer ends for each bus phase; counts are least times rounded up, the read phase adding the two-cycle sync lag
  assign lo_end = (cnt_q == 5'(`WE_CYC - 1));
  assign hi_end = (cnt_q == 5'(`REC_CYC - 1));
  assign rd_end = (cnt_q == 5'(`RD_CYC + `SYNC_LAG - 1));
  assign start_cfg = (state_q == ST_IDLE) && pwr_on_q && cfg_req;
  assign start_rd = (state_q == ST_IDLE) && pwr_on_q && stat_req && !cfg_req;

  // Next state; configuration wins if both requests arrive together
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q + 5'h01;
    case (state_q)
      ST_IDLE: begin
        cnt_d = 5'h00;
        if (start_cfg || start_rd) begin
          state_d = ST_WR_LO;
        end
      end
      ST_WR_LO: begin
        if (lo_end) begin
          state_d = ST_WR_HI;
          cnt_d = 5'h00;
        end
      end
      ST_WR_HI: begin
        if (hi_end) begin
          cnt_d = 5'h00;
          if (two_q) begin
            state_d = ST_WR_LO;
          end else if (rd_q) begin
            state_d = ST_RD;
          end else begin
            state_d = ST_FIN;
          end
        end
      end
      ST_RD: begin
        if (rd_end) begin
          state_d = ST_FIN;
          cnt_d = 5'h00;
        end
      end
      ST_FIN: begin
        state_d = ST_IDLE;
        cnt_d = 5'h00;
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = 5'h00;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Command bytes: B8h then the code with reserved bits forced to zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      byte_q <= 8'h00;
      byte2_q <= 8'h00;
      two_q <= 1'b0;
      rd_q <= 1'b0;
      cfg_q <= 1'b0;
      mode_pend_q <= MODE_LEVEL;
    end else if (start_cfg) begin
      byte_q <= `CMD_CFG;
      byte2_q <= {`CFG_RSVD_VAL, cfg_code};
      two_q <= 1'b1;
      rd_q <= 1'b0;
      cfg_q <= 1'b1;
      mode_pend_q <= pin_mode_t'(cfg_code);
    end else if (start_rd) begin
      byte_q <= `CMD_RDSTAT;
      two_q <= 1'b0;
      rd_q <= 1'b1;
      cfg_q <= 1'b0;
    end else if (state_q == ST_WR_HI && hi_end && two_q) begin
      byte_q <= byte2_q;
      two_q <= 1'b0;
    end
  end

  // Mode takes effect once both bytes are on the bus; reset returns the default
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= MODE_LEVEL;
    end else if (state_q == ST_FIN && cfg_q) begin
      mode_q <= mode_pend_q;
    end
  end

  // Data bus samples pass two stages before anything reads them
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  // Status copy is cleared by reset, as the device clears its own
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stat_q <= 8'h00;
      stat_valid_q <= 1'b0;
      cfg_done_q <= 1'b0;
    end else begin
      stat_valid_q <= (state_q == ST_RD) && rd_end;
      cfg_done_q <= (state_q == ST_FIN) && cfg_q;
      if ((state_q == ST_RD) && rd_end) begin
        stat_q <= dq_s2_q & `ST_MASK;
      end
    end
  end

  // Reset pin held low through our reset, released one edge later
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pwr_on_q <= 1'b0;
    end else begin
      pwr_on_q <= 1'b1;
    end
  end

  // Strobes decode from the Gray state; no path into write-low passes a two-bit step
  assign ce_n = (state_q == ST_IDLE) || (state_q == ST_FIN);
  assign we_n = (state_q != ST_WR_LO);
  assign oe_n = (state_q != ST_RD);
  assign dq_oe = (state_q == ST_WR_LO) || (state_q == ST_WR_HI);
  assign dq_out = byte_q;
  assign reset_powerdown_input_n = pwr_on_q;
  assign busy = (state_q != ST_IDLE) || !pwr_on_q;
  assign cfg_done = cfg_done_q;
  assign stat_valid = stat_valid_q;
  assign stat_data = stat_q;
  assign pin_mode = mode_q;

  // Decoded status fields
  assign engine_ready_flag = stat_q[`ST_READY];
  assign program_voltage_fault_flag = stat_q[`ST_VOLT];
  assign program_lock_error_flag = stat_q[`ST_PROG_ERR];
  assign erase_unlock_error_flag = stat_q[`ST_ERASE_ERR];
  assign lock_cmd_error = stat_q[`ST_PROG_ERR] && stat_q[`ST_ERASE_ERR];

  // Ready pin watcher: completion edges and level busy view
  pin_watch u_pin_watch (
    .mclk(mclk),
    .arst_n(arst_n),
    .ready_indicator_pin(ready_indicator_pin),
    .mode(mode_q),
    .ready_busy_level(ready_busy_level),
    .done_evt(done_evt),
    .pin_stuck(pin_stuck)
  );

  cfg_first_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $fell(we_n) && cfg_q && two_q |-> dq_out == `CMD_CFG && dq_oe)
    else $error("first configuration byte is not the configuration command");
  cfg_second_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $fell(we_n) && cfg_q && !two_q |-> dq_out[1:0] == mode_pend_q)
    else $error("second configuration byte carries the wrong code");
  cfg_rsvd_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $fell(we_n) && cfg_q && !two_q |-> dq_out[7:2] == `CFG_RSVD_VAL)
    else $error("reserved configuration bits not zero");
  stat_mask_a: assert property (@(posedge mclk) disable iff (!arst_n)
    stat_valid |-> !stat_data[`ST_RSVD_HI] && !stat_data[`ST_RSVD_LO])
    else $error("reserved status bits not masked");
  stat_ready_a: assert property (@(posedge mclk) disable iff (!arst_n)
    stat_valid |-> engine_ready_flag == $past(dq_s2_q[`ST_READY]))
    else $error("ready flag does not follow captured status bit seven");
  we_width_a: assert property (@(posedge mclk) disable iff (!arst_n)
    $fell(we_n) |-> !we_n [*7] ##1 we_n)
    else $error("write strobe low width wrong");
  mode_apply_a: assert property (@(posedge mclk) disable iff (!arst_n)
    cfg_done |-> pin_mode == $past(mode_pend_q))
    else $error("pin mode not updated after configuration");
  strobe_excl_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !(!we_n && !oe_n) && !(!oe_n && dq_oe))
    else $error("read and write strobes overlap");
  cov_cfg_pulse: cover property (@(posedge mclk) disable iff (!arst_n) cfg_done && pin_mode != MODE_LEVEL);
  cov_stat: cover property (@(posedge mclk) disable iff (!arst_n) stat_valid && lock_cmd_error);
  cov_level: cover property (@(posedge mclk) disable iff (!arst_n) done_evt && pin_mode == MODE_LEVEL);
endmodule : flash_status_host
`default_nettype wire

/* File: verification/flash_dev_model.sv */
`include "flash_host_map.svh"
`default_nettype none
module flash_dev_model (
  input wire logic mclk,
  input wire logic flash_rst_n,
  input wire logic dq_oe,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic [7:0] dq_wr,
  input wire logic op_go,
  input wire logic [1:0] op_kind,
  input wire logic volt_low,
  output logic [7:0] dq_rd,
  output logic pin_low,
  output logic [7:0] cfg_byte_q
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] OP_CYC = 8'h3c;
  logic [7:0] busy_q, pulse_q, last_q, stat_q;
  logic arm_q, we_q;
  logic [1:0] kind_q;
  // Reserved bits 2 and 0 read back as ones so that host masking is exercised
  wire engine_busy = busy_q != 8'h00;
  wire [7:0] status = {~engine_busy, stat_q[6:0]} | 8'h05;
  wire match = (kind_q == 2'b00 && cfg_byte_q[0]) || (kind_q == 2'b01 && cfg_byte_q[1]);
  // Level mode follows the engine, pulse modes show only the completion pulse
  assign pin_low = (cfg_byte_q[1:0] == 2'b00) ? engine_busy : (pulse_q != 8'h00);
  // A released bus toggles, so a stale byte cannot pass as fresh data
  assign dq_rd = (!ce_n && !oe_n) ? status : ~last_q;
  // Command capture on write strobe release, engine and pulse timers
  always_ff @(posedge mclk or negedge flash_rst_n) begin
    if (!flash_rst_n) begin
      busy_q <= 8'h00;
      pulse_q <= 8'h00;
      stat_q <= 8'h00;
      arm_q <= 1'b0;
      we_q <= 1'b1;
      cfg_byte_q <= 8'h00;
      kind_q <= 2'b00;
      last_q <= 8'h00;
    end else begin
      last_q <= dq_rd;
      we_q <= we_n;
      // Only a byte the host actually drives is taken as a command
      if (!ce_n && we_n && !we_q && dq_oe) begin
        arm_q <= (dq_wr == `CMD_CFG);
        if (arm_q) cfg_byte_q <= dq_wr;
      end
      if (op_go) begin
        busy_q <= OP_CYC;
        kind_q <= op_kind;
        stat_q[3] <= stat_q[3] | volt_low;
        if (op_kind == 2'b10) stat_q[5:4] <= 2'b11;
      end else if (engine_busy) begin
        busy_q <= busy_q - 8'h01;
        if (busy_q == 8'h01 && match) pulse_q <= 8'(`PULSE_CYC);
      end else if (pulse_q != 8'h00) begin
        pulse_q <= pulse_q - 8'h01;
      end
    end
  end
endmodule : flash_dev_model
`default_nettype wire

/* File: verification/tb_flash_status_host.sv */
`include "flash_host_map.svh"
`default_nettype none
module tb_flash_status_host;
  import flash_host_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, arst_n = 1'b0, cfg_req = 1'b0, stat_req = 1'b0, op_go = 1'b0, volt_low = 1'b0;
  logic pin_hold = 1'b0;
  logic [1:0] cfg_code = 2'h0, op_kind = 2'h0, pin_mode;
  logic busy, cfg_done, stat_valid, pvf, lce, rbl, done_evt, flash_rst_n, ce_n, we_n, oe_n;
  logic erf, ple, eue, stuck, dq_oe;
  logic [7:0] stat_data, dq_out, dq_in, cfg_byte, rd, lo, ev;
  wire pin_low;
  // Open drain with pull-up; pin_hold stands for another device pulling the shared line
  wire ready_pin = (pin_low || pin_hold) ? 1'b0 : 1'b1;
  int fail_count = 0, comparisons = 0;
  flash_status_host i_dut (.mclk(mclk), .arst_n(arst_n), .cfg_req(cfg_req), .cfg_code(cfg_code),
    .stat_req(stat_req), .busy(busy), .cfg_done(cfg_done), .stat_valid(stat_valid), .stat_data(stat_data),
    .engine_ready_flag(erf), .program_voltage_fault_flag(pvf), .lock_cmd_error(lce), .program_lock_error_flag(ple),
    .erase_unlock_error_flag(eue), .ready_busy_level(rbl), .done_evt(done_evt), .pin_stuck(stuck),
    .pin_mode(pin_mode), .reset_powerdown_input_n(flash_rst_n), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in), .ready_indicator_pin(ready_pin));
  flash_dev_model i_dev (.mclk(mclk), .flash_rst_n(flash_rst_n), .dq_oe(dq_oe), .ce_n(ce_n), .we_n(we_n),
    .oe_n(oe_n), .dq_wr(dq_out), .op_go(op_go), .op_kind(op_kind), .volt_low(volt_low), .dq_rd(dq_in),
    .pin_low(pin_low), .cfg_byte_q(cfg_byte));
  // Free running clock
  always #5 mclk = ~mclk;
  task automatic wrap_up();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Requests are one-cycle pulses while idle, then we wait for the finish pulse
  task automatic request(input bit is_cfg, input logic [1:0] c);
    int n;
    n = 0;
    @(negedge mclk);
    cfg_code = c;
    cfg_req = is_cfg;
    stat_req = !is_cfg;
    @(negedge mclk);
    cfg_req = 0;
    stat_req = 0;
    chk({7'h00, busy}, 8'h01);
    while ((is_cfg ? cfg_done : stat_valid) !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 200) begin
      fail_count++;
      $display("mismatch at %0t: request never finished", $time);
    end
    rd = stat_data;
  endtask : request
  task automatic run_op(input logic [1:0] k, input logic v, input int wait_cyc);
    @(negedge mclk);
    op_go = 1;
    op_kind = k;
    volt_low = v;
    @(negedge mclk);
    op_go = 0;
    volt_low = 0;
    repeat (wait_cyc) @(negedge mclk);
  endtask : run_op
  // Main sequence
  initial begin
    repeat (16) @(negedge mclk);
    arst_n = 1;
    repeat (4) @(negedge mclk);
    chk({7'h00, busy}, 8'h00);
    chk(stat_data, 8'h00);
    chk({6'h00, pin_mode}, 8'h00);
    for (int c = 1; c < 4; c++) begin
      request(1'b1, c[1:0]);
      chk(cfg_byte, {6'h00, c[1:0]});
      chk({6'h00, pin_mode}, {6'h00, c[1:0]});
      for (int k = 0; k < 2; k++) begin
        run_op(k[1:0], 1'b0, 0);
        lo = 8'h00;
        ev = 8'h00;
        repeat (120) begin
          @(negedge mclk);
          lo += {7'h00, ~ready_pin};
          ev += {7'h00, done_evt};
        end
        chk(lo, c[k] ? 8'(`PULSE_CYC) : 8'h00);
        chk(ev, {7'h00, c[k]});
        chk({7'h00, rbl}, 8'h01);
      end
    end
    // A line held low far beyond a pulse is flagged while a pulse mode is active
    pin_hold = 1'b1;
    repeat (120) @(negedge mclk);
    chk({7'h00, stuck}, 8'h01);
    pin_hold = 1'b0;
    repeat (8) @(negedge mclk);
    chk({7'h00, stuck}, 8'h00);
    request(1'b1, 2'b00);
    chk(cfg_byte, 8'h00);
    run_op(2'b01, 1'b0, 4);
    chk({7'h00, rbl}, 8'h00);
    request(1'b0, 2'b00);
    chk(rd, 8'h00);
    chk({7'h00, erf}, 8'h00);
    ev = 8'h00;
    repeat (60) begin
      @(negedge mclk);
      ev += {7'h00, done_evt};
    end
    chk(ev, 8'h01);
    chk({7'h00, rbl}, 8'h01);
    request(1'b0, 2'b00);
    chk(rd, 8'h80);
    chk({7'h00, erf}, 8'h01);
    run_op(2'b01, 1'b1, 70);
    request(1'b0, 2'b00);
    chk(rd, 8'h88);
    chk({7'h00, pvf}, 8'h01);
    run_op(2'b10, 1'b0, 70);
    request(1'b0, 2'b00);
    chk(rd, 8'hb8);
    chk({7'h00, lce}, 8'h01);
    chk({6'h00, eue, ple}, 8'h03);
    // Reset in mid-operation must wipe the device status
    run_op(2'b00, 1'b0, 1);
    arst_n = 0;
    repeat (16) @(negedge mclk);
    arst_n = 1;
    repeat (4) @(negedge mclk);
    chk(stat_data, 8'h00);
    chk({6'h00, pin_mode}, 8'h00);
    request(1'b0, 2'b00);
    chk(rd, 8'h80);
    wrap_up();
  end
  // Cuts a hang short; the sequence needs about 1300 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule : tb_flash_status_host
`default_nettype wire
